// ### mac_pfc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MAC_PFC_REGS_SVH
`define MAC_PFC_REGS_SVH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define RX_XFER_CTRL_OFS    15'h0000
`define RX_XFER_STAT_OFS    15'h0004
`define PAD_FCS_OFS         15'h0100
`define LINK_FAULT_OFS      15'h0600
`define RX_PFC_CTRL_OFS     15'h2060
`define RX_SPACE_END        15'h3FFF
`define TX_SPACE_BASE       15'h4000
`define TX_PFC_EN_OFS       15'h4600
`define TX_PFC_QUANTA0_OFS  15'h4604
`define TX_PFC_HOLDOFF0_OFS 15'h4624

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RX_PFC_FWD_BIT      16
`define PAD_FCS_RST         2'h1
`define RX_PFC_IGNORE_RST   1'b1
`define TX_PFC_QUANTA_RST   16'hFFFF
`define TX_PFC_HOLDOFF_RST  16'h0001

// ----------------------------------------
// Link ordered sets, one 32-bit column
// ----------------------------------------
`define LOCAL_FAULT_COL     32'h0100_009C
`define REMOTE_FAULT_COL    32'h0200_009C
`define IDLE_COL            32'h0707_0707
`define SEQ_COL_CTRL        4'h1
`define IDLE_COL_CTRL       4'hF

// ----------------------------------------
// Timing
// ----------------------------------------
`define QUANTA_BITS         512
`define LINE_RATE_MBPS      10000
`define QUANTA_PS           ((`QUANTA_BITS * 1000000) / `LINE_RATE_MBPS)
`define CLK_PERIOD_PS       5000
`define QUANTA_CYCLES       (`QUANTA_PS / `CLK_PERIOD_PS)
`define VALID_COL_LIMIT     127

`endif

// ### mac_pfc_pkg.sv
// Types shared by the flow control and link fault logic
package mac_pfc_pkg;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b01,
    GEN_BUSY = 2'b10
  } gen_state_t;

  typedef enum logic [1:0] {
    LF_OK     = 2'b00,
    LF_LOCAL  = 2'b01,
    LF_REMOTE = 2'b10
  } link_fault_t;

endpackage

// ### pfc_timer_if.sv
// Per-queue pause timer load and flag signals
`timescale 1ns/1ps
`default_nettype none

interface pfc_timer_if #(
  parameter int NQ = 8
);
  logic                 tick;
  logic [NQ-1:0]        load;
  logic [NQ-1:0][15:0]  quanta;
  logic [NQ-1:0]        flag;

  modport ctrl  (output tick, output load, output quanta, input flag);
  modport timer (input tick, input load, input quanta, output flag);
endinterface

`default_nettype wire

// ### pfc_pause_timers.sv
// Per-queue receive pause timers and pause flags
`timescale 1ns/1ps
`default_nettype none

module pfc_pause_timers #(
  parameter int NQ = 8
) (
  input  wire logic   clk_sys_in,  // System clock
  input  wire logic   nrst_in,     // Async reset, active low
  pfc_timer_if.timer  tmr          // Load and flag bundle
);
  typedef struct packed {
    logic [NQ-1:0][15:0] cnt;
    logic [NQ-1:0]       flag;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  // ----------------------------------------
  // Countdown per queue
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    for (int n = 0; n < NQ; n++) begin
      if (tmr.load[n]) begin
        s_d.cnt[n]  = tmr.quanta[n];
        s_d.flag[n] = (tmr.quanta[n] != 16'h0000);
      end else if (s_q.flag[n] && tmr.tick) begin
        if (s_q.cnt[n] <= 16'h0001) begin
          s_d.cnt[n]  = 16'h0000;
          s_d.flag[n] = 1'b0;
        end else begin
          s_d.cnt[n] = s_q.cnt[n] - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tmr.flag = s_q.flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  for (genvar g = 0; g < NQ; g++) begin : g_chk
    property p_load_sets;
      tmr.load[g] && (tmr.quanta[g] != 16'h0000) |=> tmr.flag[g] && (s_q.cnt[g] == $past(tmr.quanta[g]));
    endproperty
    a_load_sets: assert property (p_load_sets) else $error("pause flag not set on load");

    property p_zero_clears;
      tmr.load[g] && (tmr.quanta[g] == 16'h0000) |=> !tmr.flag[g];
    endproperty
    a_zero_clears: assert property (p_zero_clears) else $error("pause flag not cleared by zero");

    property p_expire;
      tmr.flag[g] && tmr.tick && !tmr.load[g] && (s_q.cnt[g] == 16'h0001) |=> !tmr.flag[g];
    endproperty
    a_expire: assert property (p_expire) else $error("pause flag held past expiry");
  end
endmodule

`default_nettype wire

// ### mac_pfc_link_fault.sv
// Priority flow control, link fault sublayer and register space of the MAC
//
// Functional notes
// - Two to eight priority queues chosen at build time.
// - Received priority pause frames are dropped unless forwarding is enabled.
// - Received frame with enable n and nonzero quanta raises pause flag n.
// - Received frame with enable n and zero quanta lowers pause flag n.
// - Pause flag n also falls when the queue timer runs out.
// - A newer quanta for a queue reloads its timer, replacing the count.
// - Client requests XOFF or XON per queue; device generates the frame.
// - XOFF sets enable bit n and quanta n from the queue duration register.
// - Successive XOFF requests per queue are spaced by the holdoff register.
// - XON frames carry zero quanta.
// - Local fault in sets status 01 and sends remote fault out.
// - Remote fault in sets status 10.
// - During remote fault, idle is sent on every lane.
// - MAC transmit data is discarded while fault or idle patterns go out.
// - Status returns to 00 after more than 127 valid columns.
// - Frames not addressed to the device are dropped.
// - Receive registers sit at 0x000-0x3FFF, transmit at 0x4000-0x7FFF.
`timescale 1ns/1ps
`default_nettype none
`include "mac_pfc_regs.svh"

module mac_pfc_link_fault
  import mac_pfc_pkg::*;
#(
  parameter int NQ     = 8,   // Priority queues
  parameter bit HAS_RX = 1'b1,
  parameter bit HAS_TX = 1'b1
) (
  input  wire logic             clk_sys_in,               // System clock
  input  wire logic             nrst_in,                  // Async reset, active low
  input  wire logic [12:0]      csr_address_in,           // Word address
  input  wire logic             csr_read_in,              // Read strobe
  input  wire logic             csr_write_in,             // Write strobe
  input  wire logic [31:0]      csr_writedata_in,         // Write data
  output logic      [31:0]      csr_readdata_out,         // Read data
  output logic                  csr_readvalid_out,        // Read data valid
  input  wire logic             pfc_rx_valid_in,          // Parsed pause frame pulse
  input  wire logic [7:0]       pfc_rx_enable_in,         // Parsed enable vector
  input  wire logic [NQ*16-1:0] pfc_rx_quanta_in,         // Parsed quanta, queue 0 low
  input  wire logic [63:0]      rx_data_in,               // Receive frame data
  input  wire logic             rx_valid_in,              // Receive beat valid
  input  wire logic             rx_sop_in,                // Receive start of frame
  input  wire logic             rx_eop_in,                // Receive end of frame
  input  wire logic             rx_is_pfc_in,             // Frame is a pause frame
  input  wire logic             rx_addr_match_in,         // Frame addressed to us
  output logic      [63:0]      rx_data_out,              // Client frame data
  output logic                  rx_valid_out,             // Client beat valid
  output logic                  rx_sop_out,               // Client start of frame
  output logic                  rx_eop_out,               // Client end of frame
  output logic      [NQ-1:0]    rx_queue_pause_flags_out, // Per-queue pause
  input  wire logic [2*NQ-1:0]  tx_queue_pause_request_in,// XOFF high half, XON low
  output logic                  pfc_gen_valid_out,        // Pause frame request
  output logic      [7:0]       pfc_gen_enable_out,       // Enable vector
  output logic      [NQ*16-1:0] pfc_gen_quanta_out,       // Quanta, queue 0 low
  input  wire logic             pfc_gen_ready_in,         // Frame builder accepts
  input  wire logic [63:0]      mac_txd_in,               // MAC transmit data
  input  wire logic [7:0]       mac_txc_in,               // MAC transmit control
  output logic      [63:0]      xgmii_txd_out,            // Link transmit data
  output logic      [7:0]       xgmii_txc_out,            // Link transmit control
  input  wire logic [63:0]      xgmii_rxd_in,             // Link receive data pins
  input  wire logic [7:0]       xgmii_rxc_in,             // Link receive control pins
  output logic      [1:0]       link_fault_status_out     // 00 ok, 01 local, 10 remote
);
  localparam int PRE_MAX = `QUANTA_CYCLES - 1;

  if (NQ < 2 || NQ > 8) begin : g_nq_chk
    $error("NQ must lie between 2 and 8");
  end
  if (!HAS_RX && !HAS_TX) begin : g_var_chk
    $error("at least one path must be built");
  end

  typedef struct packed {
    logic [71:0]         pin_s1;
    logic [71:0]         pin_s2;
    link_fault_t         fault;
    logic [7:0]          vcnt;
    logic [63:0]         txd;
    logic [7:0]          txc;
    logic [3:0]          pre;
    logic                tick;
    logic                rx_dis;
    logic [1:0]          pad_fcs;
    logic [NQ-1:0]       ign;
    logic                fwd;
    logic [NQ-1:0]       tx_en;
    logic [NQ-1:0][15:0] quanta;
    logic [NQ-1:0][15:0] holdoff;
    logic [NQ-1:0][15:0] hcnt;
    logic [31:0]         rdata;
    logic                rvalid;
    logic                keep;
    logic [63:0]         rxd;
    logic                rxv;
    logic                rxs;
    logic                rxe;
    gen_state_t          gen;
    logic [7:0]          gen_en;
    logic [NQ-1:0][15:0] gen_q;
    logic                gen_v;
    logic [NQ-1:0]       load;
    logic [NQ-1:0][15:0] ld_q;
  } state_t;

  state_t s_q;
  state_t s_d;

  pfc_timer_if #(.NQ(NQ)) tmr ();

  // ----------------------------------------
  // Column classifier
  // ----------------------------------------
  function automatic link_fault_t col_kind(input logic [3:0] c, input logic [31:0] d);
    link_fault_t k;
    k = LF_OK;
    if (c == `SEQ_COL_CTRL && d == `LOCAL_FAULT_COL) begin
      k = LF_LOCAL;
    end else if (c == `SEQ_COL_CTRL && d == `REMOTE_FAULT_COL) begin
      k = LF_REMOTE;
    end
    return k;
  endfunction

  logic [14:0]         byte_addr;
  logic                rx_sel;
  logic                tx_sel;
  link_fault_t         kind_lo;
  link_fault_t         kind_hi;
  logic                keep_now;
  logic [NQ-1:0]       xoff_go;
  logic [NQ-1:0]       xon_go;
  logic [NQ-1:0][15:0] rx_q;

  assign byte_addr = {csr_address_in, 2'b00};
  assign rx_sel    = HAS_RX && (byte_addr <= `RX_SPACE_END);
  assign tx_sel    = HAS_TX && (byte_addr >= `TX_SPACE_BASE);
  assign kind_lo   = col_kind(s_q.pin_s2[67:64], s_q.pin_s2[31:0]);
  assign kind_hi   = col_kind(s_q.pin_s2[71:68], s_q.pin_s2[63:32]);
  assign rx_q      = pfc_rx_quanta_in;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;

    // Pin synchroniser
    s_d.pin_s1 = {xgmii_rxc_in, xgmii_rxd_in};
    s_d.pin_s2 = s_q.pin_s1;

    // Receive fault state
    if (kind_lo == LF_LOCAL || kind_hi == LF_LOCAL) begin
      s_d.fault = LF_LOCAL;
      s_d.vcnt  = 8'h00;
    end else if (kind_lo == LF_REMOTE || kind_hi == LF_REMOTE) begin
      s_d.fault = LF_REMOTE;
      s_d.vcnt  = 8'h00;
    end else begin
      if (s_q.vcnt <= 8'(`VALID_COL_LIMIT)) begin
        s_d.vcnt = s_q.vcnt + 8'h02;
      end
      if (s_q.vcnt > 8'(`VALID_COL_LIMIT)) begin
        s_d.fault = LF_OK;
      end
    end

    // Transmit pattern select; MAC data dropped during faults
    case (s_q.fault)
      LF_LOCAL: begin
        s_d.txd = {2{`REMOTE_FAULT_COL}};
        s_d.txc = {2{`SEQ_COL_CTRL}};
      end
      LF_REMOTE: begin
        s_d.txd = {2{`IDLE_COL}};
        s_d.txc = {2{`IDLE_COL_CTRL}};
      end
      default: begin
        s_d.txd = mac_txd_in;
        s_d.txc = mac_txc_in;
      end
    endcase

    // Quanta prescaler
    s_d.tick = (s_q.pre == 4'(PRE_MAX));
    s_d.pre  = s_d.tick ? 4'h0 : s_q.pre + 4'h1;

    // Register writes
    if (csr_write_in && rx_sel) begin
      case (byte_addr)
        `RX_XFER_CTRL_OFS: s_d.rx_dis  = csr_writedata_in[0];
        `PAD_FCS_OFS:      s_d.pad_fcs = csr_writedata_in[1:0];
        `RX_PFC_CTRL_OFS: begin
          s_d.ign = csr_writedata_in[NQ-1:0];
          s_d.fwd = csr_writedata_in[`RX_PFC_FWD_BIT];
        end
        default: ;
      endcase
    end
    if (csr_write_in && tx_sel) begin
      if (byte_addr == `TX_PFC_EN_OFS) begin
        s_d.tx_en = csr_writedata_in[NQ-1:0];
      end
      for (int n = 0; n < NQ; n++) begin
        if (byte_addr == `TX_PFC_QUANTA0_OFS + 15'(4 * n)) begin
          s_d.quanta[n] = csr_writedata_in[15:0];
        end
        if (byte_addr == `TX_PFC_HOLDOFF0_OFS + 15'(4 * n)) begin
          s_d.holdoff[n] = csr_writedata_in[15:0];
        end
      end
    end

    // Register reads, unmapped words answer zero
    s_d.rvalid = csr_read_in;
    s_d.rdata  = 32'h0000_0000;
    if (csr_read_in && rx_sel) begin
      case (byte_addr)
        `RX_XFER_CTRL_OFS: s_d.rdata[0]    = s_q.rx_dis;
        `RX_XFER_STAT_OFS: s_d.rdata[0]    = s_q.rx_dis;
        `PAD_FCS_OFS:      s_d.rdata[1:0]  = s_q.pad_fcs;
        `LINK_FAULT_OFS:   s_d.rdata[1:0]  = s_q.fault;
        `RX_PFC_CTRL_OFS: begin
          s_d.rdata[NQ-1:0]            = s_q.ign;
          s_d.rdata[`RX_PFC_FWD_BIT]   = s_q.fwd;
        end
        default: ;
      endcase
    end
    if (csr_read_in && tx_sel) begin
      if (byte_addr == `TX_PFC_EN_OFS) begin
        s_d.rdata[NQ-1:0] = s_q.tx_en;
      end
      for (int n = 0; n < NQ; n++) begin
        if (byte_addr == `TX_PFC_QUANTA0_OFS + 15'(4 * n)) begin
          s_d.rdata[15:0] = s_q.quanta[n];
        end
        if (byte_addr == `TX_PFC_HOLDOFF0_OFS + 15'(4 * n)) begin
          s_d.rdata[15:0] = s_q.holdoff[n];
        end
      end
    end

    // Received pause frame: reload timers of enabled queues
    for (int n = 0; n < NQ; n++) begin
      s_d.load[n] = HAS_RX && pfc_rx_valid_in && pfc_rx_enable_in[n] && !s_q.ign[n];
      s_d.ld_q[n] = rx_q[n];
    end

    // Receive frame filter, decided at start of frame
    s_d.keep  = keep_now;
    s_d.rxd   = rx_data_in;
    s_d.rxv   = rx_valid_in && keep_now;
    s_d.rxs   = rx_sop_in;
    s_d.rxe   = rx_eop_in;

    // Holdoff counters tick in quanta
    for (int n = 0; n < NQ; n++) begin
      if (s_q.tick && s_q.hcnt[n] != 16'h0000) begin
        s_d.hcnt[n] = s_q.hcnt[n] - 16'h0001;
      end
    end

    // Pause frame generation
    case (s_q.gen)
      GEN_IDLE: begin
        if (|(xoff_go | xon_go)) begin
          s_d.gen    = GEN_BUSY;
          s_d.gen_v  = 1'b1;
          s_d.gen_en = 8'h00;
          for (int n = 0; n < NQ; n++) begin
            s_d.gen_en[n] = xoff_go[n] || xon_go[n];
            s_d.gen_q[n]  = xoff_go[n] ? s_q.quanta[n] : 16'h0000;
            if (xoff_go[n]) begin
              s_d.hcnt[n] = s_q.holdoff[n];
            end
          end
        end
      end
      GEN_BUSY: begin
        if (pfc_gen_ready_in) begin
          s_d.gen   = GEN_IDLE;
          s_d.gen_v = 1'b0;
        end
      end
      default: begin
        s_d.gen   = GEN_IDLE;
        s_d.gen_v = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  always_comb begin
    keep_now = rx_sop_in ? (!s_q.rx_dis && rx_addr_match_in && (!rx_is_pfc_in || s_q.fwd))
                         : s_q.keep;
    for (int n = 0; n < NQ; n++) begin
      xoff_go[n] = HAS_TX && tx_queue_pause_request_in[NQ+n] && s_q.tx_en[n]
                   && (s_q.hcnt[n] == 16'h0000);
      xon_go[n]  = HAS_TX && tx_queue_pause_request_in[n] && s_q.tx_en[n]
                   && !tx_queue_pause_request_in[NQ+n];
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q         <= '0;
      s_q.pad_fcs <= `PAD_FCS_RST;
      s_q.ign     <= {NQ{`RX_PFC_IGNORE_RST}};
      s_q.quanta  <= {NQ{`TX_PFC_QUANTA_RST}};
      s_q.holdoff <= {NQ{`TX_PFC_HOLDOFF_RST}};
      s_q.gen     <= GEN_IDLE;
      s_q.fault   <= LF_OK;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Timers and outputs
  // ----------------------------------------
  assign tmr.tick   = s_q.tick;
  assign tmr.load   = s_q.load;
  assign tmr.quanta = s_q.ld_q;

  pfc_pause_timers #(.NQ(NQ)) u_timers (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .tmr        (tmr)
  );

  assign csr_readdata_out         = s_q.rdata;
  assign csr_readvalid_out        = s_q.rvalid;
  assign rx_data_out              = s_q.rxd;
  assign rx_valid_out             = s_q.rxv;
  assign rx_sop_out               = s_q.rxs;
  assign rx_eop_out               = s_q.rxe;
  assign rx_queue_pause_flags_out = tmr.flag;
  assign pfc_gen_valid_out        = s_q.gen_v;
  assign pfc_gen_enable_out       = s_q.gen_en;
  assign pfc_gen_quanta_out       = s_q.gen_q;
  assign xgmii_txd_out            = s_q.txd;
  assign xgmii_txc_out            = s_q.txc;
  assign link_fault_status_out    = s_q.fault;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_local_seen;
    kind_lo == LF_LOCAL || kind_hi == LF_LOCAL;
  endsequence
  sequence s_rf_out;
    (link_fault_status_out == 2'b01) ##1 (xgmii_txd_out == {2{`REMOTE_FAULT_COL}});
  endsequence

  property p_local_fault;
    @(posedge clk_sys_in) disable iff (!nrst_in) s_local_seen |=> s_rf_out;
  endproperty
  a_local_fault: assert property (p_local_fault) else $error("local fault not handled");

  property p_remote_status;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (kind_lo == LF_REMOTE) && (kind_hi != LF_LOCAL) |=> link_fault_status_out == 2'b10;
  endproperty
  a_remote_status: assert property (p_remote_status) else $error("remote fault status wrong");

  property p_idle_out;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      link_fault_status_out == 2'b10 |=> xgmii_txd_out == {2{`IDLE_COL}} && xgmii_txc_out == 8'hFF;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle not sent on remote fault");

  property p_fault_clear;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (link_fault_status_out != 2'b00) && (s_q.vcnt > 8'(`VALID_COL_LIMIT))
        && (kind_lo == LF_OK) && (kind_hi == LF_OK) |=> link_fault_status_out == 2'b00;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault held past valid run");

  property p_drop_frame;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      rx_valid_in && rx_sop_in && (!rx_addr_match_in || (rx_is_pfc_in && !s_q.fwd)) |=> !rx_valid_out;
  endproperty
  a_drop_frame: assert property (p_drop_frame) else $error("frame not dropped");

  property p_gen_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      pfc_gen_valid_out && !pfc_gen_ready_in |=> pfc_gen_valid_out && $stable(pfc_gen_quanta_out);
  endproperty
  a_gen_hold: assert property (p_gen_hold) else $error("pause request changed while pending");

  property p_holdoff;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (s_q.gen == GEN_IDLE) && xoff_go[0] && (s_q.holdoff[0] > 16'h0001)
        |=> !xoff_go[0] ##1 !xoff_go[0];
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("XOFF spacing violated");

  property p_xon_zero;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (s_q.gen == GEN_IDLE) && xon_go[0] && !xoff_go[0] |=> pfc_gen_enable_out[0] && s_q.gen_q[0] == 16'h0000;
  endproperty
  a_xon_zero: assert property (p_xon_zero) else $error("XON quanta not zero");
endmodule

`default_nettype wire

// ### pfc_frame_sink.sv
// Frame builder model that accepts generated pause frames after a stall
`timescale 1ns/1ps
`default_nettype none
module pfc_frame_sink (
  input  wire logic clk_sys_in,    // System clock
  input  wire logic gen_valid_in,  // Pause frame request
  output var logic  gen_ready_out  // Frame accepted
);
  logic [1:0] wait_q = 2'h0;
  initial gen_ready_out = 1'b0;
  // Stall three cycles, then accept for one edge
  always @(posedge clk_sys_in) begin
    wait_q <= (gen_valid_in && !gen_ready_out) ? wait_q + 2'h1 : 2'h0;
    gen_ready_out <= gen_valid_in && !gen_ready_out && wait_q == 2'h2;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the flow control and link fault block
`timescale 1ns/1ps
`default_nettype none
`include "mac_pfc_regs.svh"
module tb_top;
  logic clk_sys_in = 0, nrst_in = 0, rd = 0, wr = 0, pv = 0, rv, gv, grdy;
  logic rxv = 0, rxs = 0, rxe = 0, ispfc = 0, am = 0, rvo, rso, reo, q0_go;
  logic [63:0] rxdo;
  logic [12:0] addr = '0;
  logic [31:0] wd = '0, rdat;
  logic [7:0] pen = '0, flags, gen, xtc, xrc = 8'hFF;
  logic [127:0] pq = '0, gq;
  logic [15:0] req = '0;
  logic [63:0] xtd, xrd = {2{`IDLE_COL}}, txd = 64'h1111_2222_3333_4444;
  logic [1:0] lfs;
  int failures = 0, comparisons = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  mac_pfc_link_fault i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .csr_address_in(addr), .csr_read_in(rd), .csr_write_in(wr), .csr_writedata_in(wd),
    .csr_readdata_out(rdat), .csr_readvalid_out(rv), .pfc_rx_valid_in(pv),
    .pfc_rx_enable_in(pen), .pfc_rx_quanta_in(pq), .rx_data_in(txd), .rx_valid_in(rxv),
    .rx_sop_in(rxs), .rx_eop_in(rxe), .rx_is_pfc_in(ispfc), .rx_addr_match_in(am),
    .rx_data_out(rxdo), .rx_valid_out(rvo), .rx_sop_out(rso), .rx_eop_out(reo),
    .rx_queue_pause_flags_out(flags), .tx_queue_pause_request_in(req),
    .pfc_gen_valid_out(gv), .pfc_gen_enable_out(gen), .pfc_gen_quanta_out(gq),
    .pfc_gen_ready_in(grdy), .mac_txd_in(txd), .mac_txc_in(8'h00),
    .xgmii_txd_out(xtd), .xgmii_txc_out(xtc), .xgmii_rxd_in(xrd), .xgmii_rxc_in(xrc),
    .link_fault_status_out(lfs));
  pfc_frame_sink i_sink (.clk_sys_in(clk_sys_in), .gen_valid_in(gv), .gen_ready_out(grdy));
  // Client queue 0 sends only while its pause flag is low
  always @(posedge clk_sys_in) q0_go <= !flags[0];

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [12:0] a, input logic [31:0] d);
    @(posedge clk_sys_in) begin addr <= a; wd <= d; wr <= 1'b1; end
    @(posedge clk_sys_in) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [12:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in) begin addr <= a; rd <= 1'b1; end
    @(posedge clk_sys_in) rd <= 1'b0;
    #1 check({rv, rdat}, {1'b1, exp});
  endtask
  task automatic pause_frame(input logic [15:0] q, input logic exp);
    @(posedge clk_sys_in) begin pv <= 1'b1; pen <= 8'h01; pq[15:0] <= q; end
    @(posedge clk_sys_in) pv <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1 check(flags[0], exp);
  endtask
  task automatic wait_gen(input logic lvl);
    for (int n = 0; n < 40 && gv !== lvl; n++) begin
      @(posedge clk_sys_in);
      #1;
    end
    check(gv, lvl);
  endtask
  task automatic complete_run;
    $display("TB summary: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd_reg(13'h0040, 32'h0000_0001);
    rd_reg(13'h1181, 32'h0000_FFFF);
    rd_reg(13'h1189, 32'h0000_0001);
    rd_reg(13'h0002, 32'h0000_0000);
    wr_reg(13'h0818, 32'h0000_0000);
    pause_frame(16'h0003, 1'b1);
    pause_frame(16'h0000, 1'b0);
    pause_frame(16'h0001, 1'b1);
    pause_frame(16'h0002, 1'b1);
    check(q0_go, 1'b0);
    repeat (30) @(posedge clk_sys_in);
    #1 check(flags[0], 1'b0);
    check(q0_go, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_in) begin
        rxv <= 1'b1; rxs <= 1'b1; rxe <= 1'b1; am <= (i != 0); ispfc <= (i == 1);
      end
      @(posedge clk_sys_in) rxv <= 1'b0;
      #1 check(rvo, i == 2);
      check({rso, reo, rxdo}, {2'b11, txd});
    end
    wr_reg(13'h1180, 32'h0000_0001);
    wr_reg(13'h1181, 32'h0000_1234);
    wr_reg(13'h1189, 32'h0000_0003);
    @(posedge clk_sys_in) req <= 16'h0100;
    wait_gen(1'b1);
    check({gen[0], gq[15:0]}, {1'b1, 16'h1234});
    wait_gen(1'b0);
    repeat (4) @(posedge clk_sys_in);
    #1 check(gv, 1'b0);
    wait_gen(1'b1);
    @(posedge clk_sys_in) req <= 16'h0000;
    wait_gen(1'b0);
    @(posedge clk_sys_in) req <= 16'h0001;
    wait_gen(1'b1);
    check(gq[15:0], 16'h0000);
    @(posedge clk_sys_in) begin req <= 16'h0000; xrd <= {2{`LOCAL_FAULT_COL}}; xrc <= 8'h11; end
    repeat (8) @(posedge clk_sys_in);
    #1 check({lfs, xtc, xtd}, {2'b01, {2{`SEQ_COL_CTRL}}, {2{`REMOTE_FAULT_COL}}});
    @(posedge clk_sys_in) xrd <= {2{`REMOTE_FAULT_COL}};
    repeat (8) @(posedge clk_sys_in);
    #1 check({lfs, xtc, xtd}, {2'b10, {2{`IDLE_COL_CTRL}}, {2{`IDLE_COL}}});
    @(posedge clk_sys_in) begin xrd <= {2{`IDLE_COL}}; xrc <= 8'hFF; end
    repeat (50) @(posedge clk_sys_in);
    #1 check(lfs, 2'b10);
    repeat (30) @(posedge clk_sys_in);
    #1 check({lfs, xtc, xtd}, {2'b00, 8'h00, txd});
    complete_run;
  end
endmodule
`default_nettype wire
